// file: amd_decoder.sv
// Address decoder with bank 00 ROM mirror and power-on reset port control.
// Overview of operation
// - Bank 00 upper reads return bank FF ROM.
// - Only FF offsets 4000h..FFFFh visible via mirror.
// - Map 004000h-00FFFFh onto FF4000h-FFFFFFh, low bits kept.
// - Ports 0,1 high-impedance while power-on and pin low.
// - Ports 0,1 undefined with pin high; ignore them.
// - Some registers reset only by power-on.
`include "amd_params.svh"
module amd_decoder #(
  parameter int PORT_W = 8
) (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic                    por,
  input  wire logic                    rst_pin_n,
  input  wire logic [`AMD_ADDR_W-1:0]  cpu_addr,
  input  wire logic                    cpu_req,
  input  wire logic [PORT_W-1:0]       p0_out_in,
  input  wire logic [PORT_W-1:0]       p1_out_in,
  input  wire logic [PORT_W-1:0]       p0_oe_n_in,
  input  wire logic [PORT_W-1:0]       p1_oe_n_in,
  input  wire logic [PORT_W-1:0]       poronly_wdata,
  input  wire logic                    poronly_we,
  output logic [`AMD_ADDR_W-1:0]       phys_addr_q,
  output amd_pkg::amd_region_t         region_q,
  output logic                         mirror_hit_q,
  output logic                         dec_valid_q,
  output logic [PORT_W-1:0]            p0_out,
  output logic [PORT_W-1:0]            p1_out,
  output logic [PORT_W-1:0]            p0_oe_n,
  output logic [PORT_W-1:0]            p1_oe_n,
  output logic                         por_busy,
  output logic [PORT_W-1:0]            poronly_q
);

  // Combinational decode results for the current address.
  logic [7:0]                 bank;        // Upper address byte.
  logic [15:0]                off;         // Offset within the bank.
  logic                       in_mirror;   // Address falls in the mirror window.
  logic [`AMD_ADDR_W-1:0]     phys_d;      // Translated address.
  amd_pkg::amd_region_t       region_d;    // Decoded region.
  amd_pkg::amd_por_t          por_q;       // Power-on sequencing state.

  // Bank and offset are plain slices; the offset is never altered downstream.
  assign bank = cpu_addr[23:16];
  assign off  = cpu_addr[15:0];

  // Mirror window test and translation; offset is carried unchanged.
  // Anything outside banks 00 and FF is handed to the external bus.
  always_comb begin
    in_mirror = (bank == `AMD_BANK_00) && (off >= `AMD_MIRROR_LO);
    phys_d    = cpu_addr;
    region_d  = amd_pkg::AMD_REG_EXT;
    if (in_mirror) begin
      phys_d   = {`AMD_BANK_FF, off};
      region_d = amd_pkg::AMD_REG_ROM;
    end else if (bank == `AMD_BANK_00) begin
      // Lower bank 00 stays in bank 00.
      if (off <= `AMD_PERIPH_HI) begin
        region_d = amd_pkg::AMD_REG_PERIPH;
      end else if (off >= `AMD_RAM_LO && off <= `AMD_RAM_HI) begin
        region_d = amd_pkg::AMD_REG_RAM;
      end else if (off >= `AMD_PERIPH2_LO && off <= `AMD_PERIPH2_HI) begin
        region_d = amd_pkg::AMD_REG_PERIPH;
      end else begin
        region_d = amd_pkg::AMD_REG_NONE;
      end
    end else if (bank == `AMD_BANK_FF) begin
      region_d = amd_pkg::AMD_REG_ROM;
    end
  end

  // Registered decode result, one cycle after the request.
  // phys_addr_q, region_q and mirror_hit_q hold until the next accepted request; dec_valid_q follows cpu_req.
  always_ff @(posedge sys_clk) begin
    if (srst || por) begin
      phys_addr_q  <= '0;
      region_q     <= amd_pkg::AMD_REG_NONE;
      mirror_hit_q <= 1'b0;
      dec_valid_q  <= 1'b0;
    end else begin
      dec_valid_q <= cpu_req;
      if (cpu_req) begin
        phys_addr_q  <= phys_d;
        region_q     <= region_d;
        mirror_hit_q <= in_mirror;
      end
    end
  end

  // Power-on sequencing: held active while por is asserted.
  // An undefined state falls back to the active state, which keeps ports safe.
  always_ff @(posedge sys_clk) begin
    if (por) begin
      por_q <= amd_pkg::AMD_POR_ACTIVE;
    end else begin
      case (por_q)
        amd_pkg::AMD_POR_ACTIVE: por_q <= amd_pkg::AMD_POR_RUN;
        amd_pkg::AMD_POR_RUN:    por_q <= amd_pkg::AMD_POR_RUN;
        default:                 por_q <= amd_pkg::AMD_POR_ACTIVE;
      endcase
    end
  end

  // Busy while power-on is asserted or its state has not yet cleared.
  assign por_busy = por || (por_q == amd_pkg::AMD_POR_ACTIVE);

  // Port drivers: released with reset pin low during power-on; with the
  // pin high their value is not defined, so the core value passes through.
  // Data lines always pass through; only the enables are overridden.
  always_comb begin
    p0_out  = p0_out_in;
    p1_out  = p1_out_in;
    p0_oe_n = p0_oe_n_in;
    p1_oe_n = p1_oe_n_in;
    if (por_busy && !rst_pin_n) begin
      p0_oe_n = '1;
      p1_oe_n = '1;
    end
    // With the pin high nothing downstream here reads the port level.
  end

  // Registers cleared only by power-on; srst leaves them alone.
  // Software can write zero or cycle power to bring these back to zero.
  always_ff @(posedge sys_clk) begin
    if (por) begin
      poronly_q <= '0;
    end else if (poronly_we) begin
      poronly_q <= poronly_wdata;
    end
  end

  // Mirror translation keeps the low 16 bits and selects bank FF.
  a_mirror_map: assert property (@(posedge sys_clk) disable iff (srst || por)
    (cpu_req && cpu_addr[23:16] == 8'h00 && cpu_addr[15:0] >= 16'h4000)
    |=> (phys_addr_q == {8'hFF, $past(cpu_addr[15:0])} && mirror_hit_q))
    else $error("Mirror address not mapped to bank FF.");

  // Mirror reads at offsets 8000h and above are served from ROM.
  a_mirror_rom: assert property (@(posedge sys_clk) disable iff (srst || por)
    (cpu_req && cpu_addr[23:16] == 8'h00 && cpu_addr[15] == 1'b1)
    |=> region_q == amd_pkg::AMD_REG_ROM)
    else $error("Mirror read not decoded as ROM.");

  // Lower bank FF offsets are not reachable via bank 00.
  a_mirror_floor: assert property (@(posedge sys_clk) disable iff (srst || por)
    (dec_valid_q && mirror_hit_q) |-> phys_addr_q[15:14] != 2'b00)
    else $error("Mirror reached below offset 4000h.");

  // Bank 00 below the window stays in bank 00.
  a_low_stays: assert property (@(posedge sys_clk) disable iff (srst || por)
    (cpu_req && cpu_addr[23:16] == 8'h00 && cpu_addr[15:14] == 2'b00)
    |=> (phys_addr_q[23:16] == 8'h00 && !mirror_hit_q))
    else $error("Low bank 00 address redirected.");

  // Ports float during power-on with the reset pin low.
  a_port_hiz: assert property (@(posedge sys_clk)
    (por && !rst_pin_n) |-> (&p0_oe_n && &p1_oe_n))
    else $error("Ports 0 or 1 driven during power-on.");

  // Power-on-only register ignores synchronous reset.
  a_poronly_hold: assert property (@(posedge sys_clk) disable iff (por)
    (srst && !poronly_we) |=> $stable(poronly_q))
    else $error("Power-on-only register changed on srst.");

  // Power-on clears the register on the following edge.
  a_poronly_clr: assert property (@(posedge sys_clk)
    por |=> poronly_q == '0)
    else $error("Power-on-only register not cleared.");

  // Ports pass through once power-on has finished.
  a_port_pass: assert property (@(posedge sys_clk) disable iff (srst)
    !por_busy |-> (p0_oe_n == p0_oe_n_in && p1_oe_n == p1_oe_n_in))
    else $error("Port enables altered after power-on.");

  // Every accepted request is answered by a valid pulse one edge later.
  // A missing pulse would leave the core waiting on stale decode data.
  a_dec_answer: assert property (@(posedge sys_clk) disable iff (srst || por)
    cpu_req |=> dec_valid_q)
    else $error("Accepted request not answered one edge later.");

  // Without a request the valid flag must not rise on its own.
  a_dec_quiet: assert property (@(posedge sys_clk) disable iff (srst || por)
    !cpu_req |=> !dec_valid_q)
    else $error("Valid flag raised without a request.");

  // Direct bank FF accesses reach ROM but are not counted as mirror hits.
  // This keeps the whole ROM, offsets below 4000h included, reachable in bank FF.
  a_bankff_direct: assert property (@(posedge sys_clk) disable iff (srst || por)
    (cpu_req && cpu_addr[23:16] == 8'hFF)
    |=> (region_q == amd_pkg::AMD_REG_ROM && !mirror_hit_q && phys_addr_q[23:16] == 8'hFF))
    else $error("Direct bank FF access decoded wrongly.");

  // Low bank 00 addresses never land in the ROM region.
  a_low_region: assert property (@(posedge sys_clk) disable iff (srst || por)
    (cpu_req && cpu_addr[23:16] == 8'h00 && cpu_addr[15:14] == 2'b00)
    |=> region_q != amd_pkg::AMD_REG_ROM)
    else $error("Low bank 00 address decoded as ROM.");

  // The port release stretches one edge past the end of power-on.
  a_busy_tail: assert property (@(posedge sys_clk)
    $fell(por) |-> por_busy)
    else $error("Power-on busy flag dropped too early.");

  // Ports float for as long as the busy flag and a low pin coincide.
  a_hiz_tail: assert property (@(posedge sys_clk)
    (por_busy && !rst_pin_n) |-> (&p0_oe_n && &p1_oe_n))
    else $error("Ports 0 or 1 driven before power-on released.");

  // A write to the power-on-only register lands on the next edge.
  a_poronly_write: assert property (@(posedge sys_clk)
    (!por && poronly_we) |=> poronly_q == $past(poronly_wdata))
    else $error("Power-on-only register write lost.");

  // A synchronous reset clears the decode outputs.
  a_srst_clear: assert property (@(posedge sys_clk)
    srst |=> (!dec_valid_q && region_q == amd_pkg::AMD_REG_NONE && !mirror_hit_q))
    else $error("Synchronous reset left decode outputs set.");

endmodule // amd_decoder

// file: amd_params.svh
// Address map constants for the bank 00 ROM mirror decoder.
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH
`define AMD_ADDR_W      24
`define AMD_BANK_00     8'h00
`define AMD_BANK_FF     8'hFF
`define AMD_MIRROR_LO   16'h4000
`define AMD_PERIPH_HI   16'h00BF
`define AMD_RAM_LO      16'h0100
`define AMD_RAM_HI      16'h18FF
`define AMD_PERIPH2_LO  16'h1900
`define AMD_PERIPH2_HI  16'h1FFF
`endif

// file: amd_pkg.sv
// Types for the bank 00 ROM mirror decoder.
package amd_pkg;
  // Region selected by the decoder for one bus address.
  typedef enum logic [2:0] {
    AMD_REG_NONE,
    AMD_REG_PERIPH,
    AMD_REG_RAM,
    AMD_REG_ROM,
    AMD_REG_EXT
  } amd_region_t;
  // Power-on sequencing states.
  typedef enum logic [1:0] {
    AMD_POR_ACTIVE,
    AMD_POR_RUN
  } amd_por_t;
endpackage

// file: amd_cpu_model.sv
// Behavioural CPU core that issues bus addresses to the decoder.
module amd_cpu_model (
  output logic [23:0] cpu_addr,
  output logic        cpu_req,
  input  wire logic   sys_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // The bus starts idle.
  initial begin
    cpu_addr = 24'h000000;
    cpu_req  = 1'b0;
  end
  // Holds one address for one taken edge, then shows its inverse, never a stale copy.
  task automatic issue(input logic [23:0] addr);
    @(negedge sys_clk);
    cpu_addr = addr;
    cpu_req  = 1'b1;
    @(negedge sys_clk);
    cpu_req  = 1'b0;
    cpu_addr = ~addr;
  endtask
endmodule // amd_cpu_model

// file: tb_amd_decoder.sv
// Self-checking bench for the bank 00 mirror decoder.
module tb_amd_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 sys_clk = 1'b0, srst = 1'b1, por = 1'b1, rst_pin_n = 1'b0, we = 1'b0;
  logic [7:0]           wd = 8'h00, oe_in = 8'h00, p0_oe_n, p1_oe_n, poronly_q, p0o, p1o;
  logic [23:0]          cpu_addr, phys;
  logic                 cpu_req, hit, dv, busy;
  amd_pkg::amd_region_t region;
  int                   n_mismatch = 0, checks_done = 0, cycles = 0;
  // Clock of 100 ns period.
  always #50 sys_clk = ~sys_clk;
  amd_cpu_model u_amd_cpu_model (.sys_clk(sys_clk), .cpu_addr(cpu_addr), .cpu_req(cpu_req));
  amd_decoder u_amd_decoder (.sys_clk(sys_clk), .srst(srst), .por(por), .rst_pin_n(rst_pin_n),
    .cpu_addr(cpu_addr), .cpu_req(cpu_req), .p0_out_in(8'h3C), .p1_out_in(8'hC3),
    .p0_oe_n_in(oe_in), .p1_oe_n_in(oe_in), .poronly_wdata(wd), .poronly_we(we),
    .phys_addr_q(phys), .region_q(region), .mirror_hit_q(hit), .dec_valid_q(dv), .p0_out(p0o),
    .p1_out(p1o), .p0_oe_n(p0_oe_n), .p1_oe_n(p1_oe_n), .por_busy(busy),
    .poronly_q(poronly_q));
  // Compares one value and counts it.
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issues one address and checks the answer one cycle later.
  task automatic decode(input logic [23:0] a, ph, input amd_pkg::amd_region_t r);
    logic hit_exp;
    hit_exp = (a[23:16] == 8'h00) && (a[15:0] >= 16'h4000);
    u_amd_cpu_model.issue(a);
    chk("dec_valid_q", 24'h1, {23'h0, dv});
    chk("phys_addr_q", ph, phys);
    chk("region_q", {21'h0, r}, {21'h0, region});
    chk("mirror_hit_q", {23'h0, hit_exp}, {23'h0, hit});
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // The power-on-only register survives srst but not por.
  task automatic poronly_scn();
    @(negedge sys_clk);
    wd = 8'hA5;
    we = 1'b1;
    @(negedge sys_clk);
    we = 1'b0;
    srst = 1'b1;
    @(negedge sys_clk);
    srst = 1'b0;
    chk("poronly_q", 24'hA5, {16'h0, poronly_q});
    por = 1'b1;
    @(negedge sys_clk);
    por = 1'b0;
    chk("poronly_q", 24'h00, {16'h0, poronly_q});
  endtask
  // Port drivers float during power-on with the pin low.
  task automatic port_scn();
    @(negedge sys_clk);
    por = 1'b1;
    oe_in = 8'h5A;
    #1;
    chk("p0_oe_n", 24'hFF, {16'h0, p0_oe_n});
    chk("p1_oe_n", 24'hFF, {16'h0, p1_oe_n});
    chk("por_busy", 24'h1, {23'h0, busy});
    rst_pin_n = 1'b1; // Pin high: port level is left unchecked.
    @(negedge sys_clk);
    por = 1'b0;
    rst_pin_n = 1'b0;
    #1;
    chk("por_busy", 24'h1, {23'h0, busy});
    chk("p1_oe_n", 24'hFF, {16'h0, p1_oe_n});
    repeat (2) @(negedge sys_clk);
    chk("por_busy", 24'h0, {23'h0, busy});
    chk("p0_oe_n", 24'h5A, {16'h0, p0_oe_n});
    chk("p1_oe_n", 24'h5A, {16'h0, p1_oe_n});
    chk("p0_out", 24'h3C, {16'h0, p0o});
    chk("p1_out", 24'hC3, {16'h0, p1o});
  endtask
  // Main sequence after five cycles of reset.
  initial begin
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    por = 1'b0;
    poronly_scn();
    port_scn();
    decode(24'h004000, 24'hFF4000, amd_pkg::AMD_REG_ROM);
    decode(24'h00C000, 24'hFFC000, amd_pkg::AMD_REG_ROM);
    decode(24'h00FFFF, 24'hFFFFFF, amd_pkg::AMD_REG_ROM);
    decode(24'h003FFF, 24'h003FFF, amd_pkg::AMD_REG_NONE);
    decode(24'h000100, 24'h000100, amd_pkg::AMD_REG_RAM);
    decode(24'h000050, 24'h000050, amd_pkg::AMD_REG_PERIPH);
    decode(24'h001900, 24'h001900, amd_pkg::AMD_REG_PERIPH);
    decode(24'hFF1234, 24'hFF1234, amd_pkg::AMD_REG_ROM);
    decode(24'h123456, 24'h123456, amd_pkg::AMD_REG_EXT);
    results();
  end
  // Cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 400) begin
      n_mismatch++;
      results();
    end
  end
endmodule // tb_amd_decoder
